/* data_memory_sector_addressing.sv */
// Data memory address decoder and indirect-addressing unit
`timescale 1ns/10ps
module data_memory_sector_addressing
  import dm_pkg::*;
#(
  parameter int           RAM_DEPTH = 512,
  parameter logic [127:0] USED_MASK = SFR_USED_DEFAULT,
  parameter logic [127:0] RO_MASK   = SFR_RO_DEFAULT
)
(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  // Access request from the core
  input  wire logic             acc_valid,
  input  wire logic             acc_write,
  input  wire logic             acc_bit_set,
  input  wire logic             acc_bit_clr,
  input  wire logic [2:0]       acc_bit_sel,
  input  wire logic             acc_ext,
  input  wire logic [EXT_W-1:0] acc_addr,
  input  wire logic [7:0]       acc_wdata,
  // Answer to the core
  output logic                  rd_valid,
  output logic [7:0]            rd_data,
  output logic [EXT_W-1:0]      eff_addr,
  output logic                  eff_none,
  // Nonvolatile memory control register
  output logic [7:0]            nvm_control
);

  // ****************************************************************
  // Storage
  // ****************************************************************

  dm_access_if ram_bus ();
  dm_access_if reg_bus ();

  // Pointer bytes and control register read back from the bank
  logic [7:0] pointer_zero;
  logic [7:0] pointer_one_low;
  logic [7:0] pointer_one_sector;
  logic [7:0] pointer_two_low;
  logic [7:0] pointer_two_sector;
  logic [7:0] nvm_control_reg;

  gp_ram #(
    .DEPTH (RAM_DEPTH)
  ) u_ram (
    .sys_clk (sys_clk),
    .acc     (ram_bus)
  );

  sfr_bank #(
    .USED_MASK (USED_MASK),
    .RO_MASK   (RO_MASK)
  ) u_sfr (
    .sys_clk            (sys_clk),
    .rst_b              (rst_b),
    .acc                (reg_bus),
    .pointer_zero       (pointer_zero),
    .pointer_one_low    (pointer_one_low),
    .pointer_one_sector (pointer_one_sector),
    .pointer_two_low    (pointer_two_low),
    .pointer_two_sector (pointer_two_sector),
    .nvm_control_reg    (nvm_control_reg)
  );

  // ****************************************************************
  // Address resolution
  // ****************************************************************

  // Direct and resolved views of the request
  logic [7:0] dir_sector;
  logic [7:0] dir_ofs;
  logic [7:0] res_sector;
  logic [7:0] res_ofs;
  logic       is_indirect;
  logic       hits_port;
  target_t    target;

  // Sector comes only from the address or the pointer sector bytes
  always_comb
  begin
    dir_ofs = acc_addr[7:0];
    if (acc_ext)
      dir_sector = {6'h00, acc_addr[9:8]};
    else
      dir_sector = 8'h00;
  end

  // Port hit check shared by direct and indirect decode
  function automatic logic is_port(input logic [7:0] sec, input logic [7:0] ofs);
    logic in_area;
    in_area = (sec == 8'h00) && !ofs[7];
    case (ofs[6:0])
      OFS_PORT_ZERO: is_port = in_area;
      OFS_PORT_ONE:  is_port = in_area;
      OFS_PORT_TWO:  is_port = in_area;
      default:       is_port = 1'b0;
    endcase
  endfunction : is_port

  logic [7:0] ptr_sector;
  logic [7:0] ptr_ofs;

  // Pointer pair behind the addressed port; port two is the default arm
  always_comb
  begin
    case (dir_ofs[6:0])
      OFS_PORT_ZERO:
      begin
        ptr_sector = 8'h00;
        ptr_ofs    = pointer_zero;
      end
      OFS_PORT_ONE:
      begin
        ptr_sector = pointer_one_sector;
        ptr_ofs    = pointer_one_low;
      end
      default:
      begin
        ptr_sector = pointer_two_sector;
        ptr_ofs    = pointer_two_low;
      end
    endcase
  end

  // A port has no storage of its own: follow its pointer
  always_comb
  begin
    is_indirect = is_port(dir_sector, dir_ofs);
    if (is_indirect)
    begin
      res_sector = ptr_sector;
      res_ofs    = ptr_ofs;
    end
    else
    begin
      res_sector = dir_sector;
      res_ofs    = dir_ofs;
    end
    // A pointer aimed back at a port lands nowhere
    hits_port = is_indirect && is_port(res_sector, res_ofs);
  end

  // ****************************************************************
  // Region of the resolved location
  // ****************************************************************

  logic       res_in_ram;
  logic       res_in_sfr;
  logic       res_sfr_used;
  logic       res_is_nvm;

  // Sector byte compared in full, so a stray high bit reaches nothing
  always_comb
  begin
    res_in_ram   = (res_ofs >= RAM_FIRST) && (res_sector <= SECTOR_LAST);
    res_in_sfr   = (res_ofs <= SFR_LAST) && (res_sector == 8'h00);
    res_sfr_used = USED_MASK[res_ofs[6:0]];
    res_is_nvm   = (res_sector == 8'h01) && (res_ofs == NVM_CTRL_OFS);
  end

  // Classify; an unused register counts as landing nowhere
  always_comb
  begin
    if (hits_port)
      target = TGT_NONE;
    else if (res_in_ram)
      target = TGT_RAM;
    else if (res_in_sfr && res_sfr_used)
      target = TGT_SFR;
    else if (res_is_nvm)
      target = TGT_NVM;
    else
      target = TGT_NONE;
  end

  // ****************************************************************
  // Request qualifiers
  // ****************************************************************

  logic       op_set;
  logic       op_clr;
  logic       op_wr;
  logic       ram_hit;
  logic       reg_hit;

  // Set wins over clear and clear over a byte write, as in the merge
  always_comb
  begin
    op_set = acc_bit_set;
    op_clr = acc_bit_clr && !acc_bit_set;
    op_wr  = acc_write && !acc_bit_set && !acc_bit_clr;
  end

  // Only a taken request selects a store; misses touch nothing
  always_comb
  begin
    ram_hit = acc_valid && (target == TGT_RAM);
    reg_hit = acc_valid && (target == TGT_SFR || target == TGT_NVM);
  end

  // ****************************************************************
  // Drive the storage modules
  // ****************************************************************

  // RAM address is sector bits above the seven in-sector bits
  always_comb
  begin
    ram_bus.sel   = ram_hit;
    ram_bus.wr    = op_wr;
    ram_bus.bset  = op_set;
    ram_bus.bclr  = op_clr;
    ram_bus.bsel  = acc_bit_sel;
    ram_bus.addr  = {res_sector[1:0], res_ofs[6:0]};
    ram_bus.wdata = acc_wdata;
  end

  // Register bank; addr[7] marks the sector-1 control register
  always_comb
  begin
    reg_bus.sel   = reg_hit;
    reg_bus.wr    = op_wr;
    reg_bus.bset  = op_set;
    reg_bus.bclr  = op_clr;
    reg_bus.bsel  = acc_bit_sel;
    reg_bus.addr  = {1'b0, (target == TGT_NVM), res_ofs[6:0]};
    reg_bus.wdata = acc_wdata;
  end

  // ****************************************************************
  // Answer
  // ****************************************************************

  logic [7:0] next_rd_data;

  // Unmapped and port-to-port reads give zero
  always_comb
  begin
    case (target)
      TGT_RAM: next_rd_data = ram_bus.rdata;
      TGT_SFR: next_rd_data = reg_bus.rdata;
      TGT_NVM: next_rd_data = reg_bus.rdata;
      default: next_rd_data = READ_ZERO;
    endcase
  end

  // One answer pulse per taken request, writes included
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_valid <= 1'b0;
    else
      rd_valid <= acc_valid;
  end

  // Read data is the value before any write of the same access
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_data <= READ_ZERO;
    else if (acc_valid)
      rd_data <= next_rd_data;
  end

  // ****************************************************************
  // Trace
  // ****************************************************************

  logic [EXT_W-1:0] next_eff_addr;
  logic             next_eff_none;

  // Sector bits above the low two are dropped here; eff_none still marks them
  always_comb
  begin
    next_eff_addr = {res_sector[1:0], res_ofs};
    next_eff_none = (target == TGT_NONE);
  end

  // Resolved location of the last access
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      eff_addr <= '0;
    else if (acc_valid)
      eff_addr <= next_eff_addr;
  end

  // Whether the last access landed nowhere
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      eff_none <= 1'b0;
    else if (acc_valid)
      eff_none <= next_eff_none;
  end

  // Registered copy so the output comes from a flop
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      nvm_control <= NVM_CTRL_RESET;
    else
      nvm_control <= nvm_control_reg;
  end

endmodule : data_memory_sector_addressing

/* dm_pkg.sv */
// Package of constants, types and helpers shared by the data memory files
// ****************************************************************
// Overview of operation
// - Every location is one byte wide
// - In-sector 00H-7FH of sector 0 decodes to special-function area
// - In-sector 80H-FFH is RAM, sectors 0-3
// - Sector 1 00H-7FH holds only the nvm control register
// - Unused special-function addresses read as zero
// - RAM read/write; bit ops touch one bit
// - Read-only and unused locations ignore writes; others read/write
// - Indirect ports store nothing, redirect through pointers
// - Port zero uses pointer_zero, sector 0 only
// - Ports one/two: sector byte plus low byte
// - Indirect access to a port: reads zero, writes nothing
// - Five pointer bytes are ordinary registers
// - No bank register; sector from pointers or address
// - Extended address 10 bits: sector plus offset
// ****************************************************************
package dm_pkg;

  // Widths
  localparam int DATA_W   = 8;
  localparam int EXT_W    = 10;
  localparam int RAM_AW   = 9;
  localparam int SFR_CNT  = 128;

  // Sector layout
  localparam logic [7:0] SFR_LAST     = 8'h7f;
  localparam logic [7:0] RAM_FIRST    = 8'h80;
  localparam logic [7:0] NVM_CTRL_OFS = 8'h40;
  localparam logic [7:0] SECTOR_LAST  = 8'h03;

  // Sector-0 offsets of the ports and pointers
  localparam logic [6:0] OFS_PORT_ZERO      = 7'h00;
  localparam logic [6:0] OFS_POINTER_ZERO   = 7'h01;
  localparam logic [6:0] OFS_PORT_ONE       = 7'h02;
  localparam logic [6:0] OFS_POINTER_ONE_L  = 7'h03;
  localparam logic [6:0] OFS_PORT_TWO       = 7'h04;
  localparam logic [6:0] OFS_POINTER_TWO_L  = 7'h05;
  localparam logic [6:0] OFS_POINTER_ONE_S  = 7'h06;
  localparam logic [6:0] OFS_POINTER_TWO_S  = 7'h07;

  // Which special-function locations exist and which are read-only
  localparam logic [127:0] SFR_USED_DEFAULT = 128'hffff_ffff_ffff_ffff_ffff_ffff_ffff_ffea;
  localparam logic [127:0] SFR_RO_DEFAULT   = 128'h0;

  // Reset values
  localparam logic [7:0] SFR_RESET      = 8'h00;
  localparam logic [7:0] NVM_CTRL_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO      = 8'h00;

  // Where a resolved access lands
  typedef enum {TGT_NONE, TGT_RAM, TGT_SFR, TGT_NVM} target_t;

  // New byte for a write or a single-bit set/clear
  function automatic logic [7:0] merge_byte(input logic [7:0] old_val,
                                            input logic [7:0] wdata,
                                            input logic       bset,
                                            input logic       bclr,
                                            input logic [2:0] bsel);
    logic [7:0] mask;
    mask = 8'h01 << bsel;
    if (bset)
      merge_byte = old_val | mask;
    else if (bclr)
      merge_byte = old_val & ~mask;
    else
      merge_byte = wdata;
  endfunction : merge_byte

endpackage : dm_pkg

/* dm_access_if.sv */
// Interface carrying one resolved byte access to a storage module
`timescale 1ns/10ps
interface dm_access_if;
  import dm_pkg::*;

  logic              sel;
  logic              wr;
  logic              bset;
  logic              bclr;
  logic [2:0]        bsel;
  logic [RAM_AW-1:0] addr;
  logic [7:0]        wdata;
  logic [7:0]        rdata;

  modport master (output sel, output wr, output bset, output bclr, output bsel,
                  output addr, output wdata, input rdata);
  modport target (input sel, input wr, input bset, input bclr, input bsel,
                  input addr, input wdata, output rdata);
endinterface : dm_access_if

/* gp_ram.sv */
// General-purpose RAM of sectors 0 to 3
`timescale 1ns/10ps
module gp_ram
  import dm_pkg::*;
#(
  parameter int DEPTH = 512
)
(
  // Clock
  input  wire logic  sys_clk,
  // Access
  dm_access_if.target acc
);

  logic [7:0] mem [DEPTH];

  // Combinational read so bit ops merge within the access cycle
  assign acc.rdata = mem[acc.addr];

  // Byte write or single-bit modify; RAM content has no reset value
  always_ff @(posedge sys_clk)
  begin
    if (acc.sel && (acc.wr || acc.bset || acc.bclr))
      mem[acc.addr] <= merge_byte(mem[acc.addr], acc.wdata,
                                  acc.bset, acc.bclr, acc.bsel);
  end

endmodule : gp_ram

/* sfr_bank.sv */
// Special-function storage: sector-0 area and the sector-1 nvm register
`timescale 1ns/10ps
module sfr_bank
  import dm_pkg::*;
#(
  parameter logic [127:0] USED_MASK = SFR_USED_DEFAULT,
  parameter logic [127:0] RO_MASK   = SFR_RO_DEFAULT
)
(
  // Clock and reset
  input  wire logic  sys_clk,
  input  wire logic  rst_b,
  // Access; addr[7] picks the sector-1 register
  dm_access_if.target acc,
  // Pointer bytes and control register
  output logic [7:0] pointer_zero,
  output logic [7:0] pointer_one_low,
  output logic [7:0] pointer_one_sector,
  output logic [7:0] pointer_two_low,
  output logic [7:0] pointer_two_sector,
  output logic [7:0] nvm_control_reg
);

  logic [7:0] sfr_mem [SFR_CNT];
  logic       modify;
  logic [6:0] ofs;

  assign modify = acc.sel && (acc.wr || acc.bset || acc.bclr);
  assign ofs    = acc.addr[6:0];

  // Unused locations read zero; the ports are unused by mask
  always_comb
  begin
    if (acc.addr[7])
      acc.rdata = nvm_control_reg;
    else if (USED_MASK[ofs])
      acc.rdata = sfr_mem[ofs];
    else
      acc.rdata = READ_ZERO;
  end

  // One byte per location; read-only and unused ones ignore writes
  genvar i;
  generate
    for (i = 0; i < SFR_CNT; i++)
    begin : g_sfr
      always_ff @(posedge sys_clk or negedge rst_b)
      begin
        if (!rst_b)
          sfr_mem[i] <= SFR_RESET;
        else if (modify && !acc.addr[7] && ofs == 7'(i)
                 && USED_MASK[i] && !RO_MASK[i])
          sfr_mem[i] <= merge_byte(sfr_mem[i], acc.wdata,
                                   acc.bset, acc.bclr, acc.bsel);
      end
    end
  endgenerate

  // Sector-1 register, only location there
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      nvm_control_reg <= NVM_CTRL_RESET;
    else if (modify && acc.addr[7])
      nvm_control_reg <= merge_byte(nvm_control_reg, acc.wdata,
                                    acc.bset, acc.bclr, acc.bsel);
  end

  // Pointers are plain stored bytes
  assign pointer_zero       = sfr_mem[OFS_POINTER_ZERO];
  assign pointer_one_low    = sfr_mem[OFS_POINTER_ONE_L];
  assign pointer_one_sector = sfr_mem[OFS_POINTER_ONE_S];
  assign pointer_two_low    = sfr_mem[OFS_POINTER_TWO_L];
  assign pointer_two_sector = sfr_mem[OFS_POINTER_TWO_S];

endmodule : sfr_bank

/* dm_sector_chk.sv */
// Port-level assertions for the data memory decoder
`timescale 1ns/10ps
// **********
// Checker
// **********
module dm_sector_chk
  import dm_pkg::*;
#(
  parameter logic [127:0] USED_MASK = SFR_USED_DEFAULT
)
(
  // Clock and reset
  input wire logic             sys_clk,
  input wire logic             rst_b,
  // Request
  input wire logic             acc_valid,
  input wire logic             acc_write,
  input wire logic             acc_bit_set,
  input wire logic             acc_bit_clr,
  input wire logic             acc_ext,
  input wire logic [EXT_W-1:0] acc_addr,
  input wire logic [7:0]       acc_wdata,
  // Answer
  input wire logic             rd_valid,
  input wire logic [7:0]       rd_data,
  input wire logic [EXT_W-1:0] eff_addr,
  input wire logic             eff_none,
  input wire logic [7:0]       nvm_control
);
  logic [EXT_W-1:0] last_addr;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Last request address, so resolved addresses need no deep history
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      last_addr <= '0;
    else if (acc_valid)
      last_addr <= acc_addr;

  // Plain byte write straight to the sector-1 control location
  sequence s_nvm_write;
    acc_valid && acc_write && !acc_bit_set && !acc_bit_clr && acc_ext && acc_addr == 10'h140;
  endsequence

  // Copy shows the stored byte one cycle after the store
  property p_nvm_copy;
    logic [7:0] d;
    (s_nvm_write, d = acc_wdata) |=> ##1 nvm_control == d;
  endproperty

  a_answer_next: assert property (acc_valid |=> rd_valid)
    else $error("no answer one cycle after a request");
  a_idle_hold: assert property (
    !acc_valid |=> !rd_valid && $stable(rd_data) && $stable(eff_none))
    else $error("answer changed without a request");
  a_ext_ram: assert property (
    acc_valid && acc_ext && acc_addr[7] |=> eff_addr == last_addr && !eff_none)
    else $error("extended RAM access resolved elsewhere");
  a_std_sector: assert property (
    acc_valid && !acc_ext && acc_addr[7] |=> eff_addr == {2'b00, last_addr[7:0]})
    else $error("standard access left sector 0");
  a_upper_sfr: assert property (
    acc_valid && acc_ext && acc_addr[9] && !acc_addr[7] |=> rd_data == 8'h00 && eff_none)
    else $error("sector 2 or 3 register area not empty");
  a_sector_one: assert property (
    acc_valid && acc_ext && acc_addr[9:8] == 2'b01 && !acc_addr[7] && acc_addr[6:0] != 7'h40
    |=> rd_data == 8'h00 && eff_none)
    else $error("sector 1 location other than control register answered");
  a_unused_zero: assert property (
    acc_valid && (!acc_ext || acc_addr[9:8] == 2'b00) && !acc_addr[7]
    && acc_addr[6:3] != 4'h0 && !USED_MASK[acc_addr[6:0]]
    |=> rd_data == 8'h00 && eff_none)
    else $error("unused register location read non-zero");
  a_nvm_copy: assert property (p_nvm_copy)
    else $error("control register copy wrong after write");

endmodule : dm_sector_chk

bind data_memory_sector_addressing dm_sector_chk #(.USED_MASK(USED_MASK)) u_dm_sector_chk
  (.sys_clk, .rst_b, .acc_valid, .acc_write, .acc_bit_set, .acc_bit_clr, .acc_ext, .acc_addr,
   .acc_wdata, .rd_valid, .rd_data, .eff_addr, .eff_none, .nvm_control);

/* core_model.sv */
// Core-side model issuing data memory accesses
`timescale 1ns/10ps
module core_model
  import dm_pkg::*;
(
  // Clock
  input  wire logic             sys_clk,
  // Request to the decoder
  output logic                  acc_valid,
  output logic                  acc_write,
  output logic                  acc_bit_set,
  output logic                  acc_bit_clr,
  output logic [2:0]            acc_bit_sel,
  output logic                  acc_ext,
  output logic [EXT_W-1:0]      acc_addr,
  output logic [7:0]            acc_wdata
);
  // Quiet bus at time zero
  initial
    {acc_valid, acc_write, acc_bit_set, acc_bit_clr, acc_bit_sel, acc_ext, acc_addr, acc_wdata} = '0;

  // Held for one whole cycle; callers chain these back to back
  task automatic issue(input logic w, st, cl, input logic [2:0] b, input logic e,
                       input logic [EXT_W-1:0] a, input logic [7:0] d);
    {acc_valid, acc_write, acc_bit_set, acc_bit_clr, acc_bit_sel, acc_ext, acc_addr, acc_wdata} =
      {1'b1, w, st, cl, b, e, a, d};
    @(posedge sys_clk);
    #2;
  endtask : issue

  // Released lines flip so a stale value is never mistaken for a live one
  task automatic idle;
    {acc_valid, acc_addr, acc_wdata} = {1'b0, ~acc_addr, ~acc_wdata};
  endtask : idle
endmodule : core_model

/* testbench.sv */
// Self-checking testbench for the data memory decoder
`timescale 1ns/10ps
module testbench;
  import dm_pkg::*;
  localparam logic [8:0] NX = {1'b0, 8'hxx};
  logic       sys_clk, rst_b, acc_valid, acc_write, acc_bit_set, acc_bit_clr, acc_ext;
  logic       rd_valid, eff_none;
  logic [2:0] acc_bit_sel;
  logic [9:0] acc_addr, eff_addr;
  logic [7:0] acc_wdata, rd_data, nvm_control;
  logic [7:0] dat [4];
  logic [7:0] ofs [4];
  logic [8:0] exp_q [$];
  int         fail_count, compares, seed, i;

  core_model u_core_model (.sys_clk, .acc_valid, .acc_write, .acc_bit_set, .acc_bit_clr,
                           .acc_bit_sel, .acc_ext, .acc_addr, .acc_wdata);
  // 7F unused and 7E read-only, so both refusals are reachable
  data_memory_sector_addressing #(.USED_MASK(SFR_USED_DEFAULT & ~(128'h1 << 127)),
    .RO_MASK(128'h1 << 126)) u_data_memory_sector_addressing (.sys_clk, .rst_b, .acc_valid,
    .acc_write, .acc_bit_set, .acc_bit_clr, .acc_bit_sel, .acc_ext, .acc_addr, .acc_wdata,
    .rd_valid, .rd_data, .eff_addr, .eff_none, .nvm_control);

  // Clock
  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  // Data bits of xx mean the old byte is unknown RAM content
  task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got[9:8] !== exp[9:8] || (exp[7:0] !== 8'hxx && got[7:0] !== exp[7:0]))
    begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic acc(input logic w, st, cl, input logic [2:0] b, input logic e,
                     input logic [9:0] a, input logic [7:0] d, input logic [8:0] x);
    exp_q.push_back(x);
    u_core_model.issue(w, st, cl, b, e, a, d);
  endtask : acc

  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [8:0] x);
    acc(1'b1, 1'b0, 1'b0, 3'h0, 1'b1, a, d, x);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [8:0] x);
    acc(1'b0, 1'b0, 1'b0, 3'h0, 1'b1, a, 8'h00, x);
  endtask : rd

  task automatic report_and_stop;
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  // Answer watcher: oldest note against each answer
  always @(posedge sys_clk)
  begin
    #1;
    if (rd_valid === 1'b1)
      if (exp_q.size() > 0)
        cmp({1'b0, eff_none, rd_data}, {1'b0, exp_q.pop_front()});
      else
        cmp(10'h3ff, 10'h000);
  end

  // Watchdog, far beyond the sixty or so cycles the run needs
  initial
  begin
    repeat (1000) @(posedge sys_clk);
    fail_count++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    seed = 23625;
    fail_count = 0;
    compares = 0;
    rst_b = 1'b0;
    repeat (20) @(posedge sys_clk);
    #2;
    cmp({rd_valid, eff_none, rd_data}, 10'h000);
    cmp(eff_addr, 10'h000);
    cmp({2'b00, nvm_control}, 10'h000);
    rst_b = 1'b1;
    for (i = 0; i < 4; i++)
    begin
      dat[i] = 8'($random(seed));
      ofs[i] = 8'h80 | 8'($random(seed));
      wr({i[1:0], ofs[i]}, dat[i], NX);
    end
    for (i = 0; i < 4; i++)
      rd({i[1:0], ofs[i]}, {1'b0, dat[i]});
    acc(1'b1, 1'b0, 1'b0, 3'h0, 1'b0, 10'h3c5, 8'h3c, NX);
    acc(1'b1, 1'b1, 1'b0, 3'h7, 1'b0, 10'h0c5, 8'h00, 9'h03c);
    acc(1'b0, 1'b0, 1'b1, 3'h2, 1'b0, 10'h0c5, 8'hff, 9'h0bc);
    rd(10'h0c5, 9'h0b8);
    wr(10'h07d, 8'h3c, 9'h000);
    rd(10'h07d, 9'h03c);
    wr(10'h07e, 8'hff, 9'h000);
    rd(10'h07e, 9'h000);
    wr(10'h07f, 8'h55, 9'h100);
    rd(10'h07f, 9'h100);
    rd(10'h210, 9'h100);
    rd(10'h141, 9'h100);
    wr(10'h001, 8'h85, 9'h000);
    rd(10'h001, 9'h085);
    wr(10'h000, 8'h5a, NX);
    rd(10'h085, 9'h05a);
    wr(10'h001, 8'h02, 9'h085);
    rd(10'h000, 9'h100);
    wr(10'h000, 8'h77, 9'h100);
    rd(10'h001, 9'h002);
    wr(10'h007, 8'h02, 9'h000);
    wr(10'h005, 8'h90, 9'h000);
    wr(10'h004, 8'hc3, NX);
    rd(10'h290, 9'h0c3);
    wr(10'h007, 8'h04, 9'h002);
    rd(10'h004, 9'h100);
    wr(10'h006, 8'h01, 9'h000);
    wr(10'h003, 8'h40, 9'h000);
    wr(10'h002, 8'ha5, 9'h000);
    rd(10'h140, 9'h0a5);
    wr(10'h140, 8'h5c, 9'h0a5);
    rd(10'h002, 9'h05c);
    u_core_model.idle();
    repeat (3) @(posedge sys_clk);
    #2;
    cmp({2'b00, nvm_control}, 10'h05c);
    cmp(10'(exp_q.size()), 10'h000);
    report_and_stop();
  end
endmodule : testbench
